// ### logic/logic_slice_cell.sv
// What this block does
// - each table maps four inputs through a sixteen-entry truth table
// - multipurpose input selects between the two tables, giving a five-input function
// - each table output feeds a storage element, flip-flop or latch per element
// - local set/clear forces storage, either synchronously or asynchronously
// - storage responds to either clock polarity, edge or level
// - slice has 13 routing inputs plus carry in; 6 outputs plus carry out
// - outputs are table bypass, storage, five-input mux and wide mux results
// - ram-capable tile supports four modes; logic-only tile lacks ram
// - ripple mode adds, subtracts, add/subtracts, counts up/down, multiplies
// - ripple mode compares A and B: ge, ne, le
// - ripple slices form generate/propagate and pass carry along the chain
// - ram mode makes each slice a 16x2 single-port memory
// - dual-port pairs two slices; companion gives a read-only port
// - rom mode reads the two tables as logic mode does, on separate inputs, and has no write port
// - tile holds four slices, 54 inputs and 25 outputs
// - six, seven and eight input functions chain wide muxes; eight spans tiles
`timescale 1ns/100ps
`default_nettype none
module logic_slice_cell
  import slice_pkg::*;
#(
  parameter bit TILE_HAS_RAM = 1'b1
) (
  // clock and reset
  input  wire logic            ref_clk,
  input  wire logic            srst,
  // register bus
  input  wire logic [7:0]      address,
  input  wire logic            read,
  input  wire logic            write,
  input  wire logic [31:0]     writedata,
  input  wire logic [3:0]      byteenable,
  output logic      [31:0]     readdata,
  output logic                 waitrequest,
  // routing inputs
  input  wire logic [3:0][7:0] table_in,
  input  wire logic [3:0][1:0] multipurpose_in,
  input  wire logic [3:0]      clk_enable,
  input  wire logic [3:0]      local_set_clear,
  input  wire logic [3:0]      slice_clk,
  input  wire logic            fast_carry_input,
  input  wire logic            wide_chain_in,
  // routing outputs
  output logic      [3:0][1:0] table_bypass_out,
  output logic      [3:0][1:0] storage_out,
  output logic      [3:0]      five_input_mux_out,
  output logic      [3:0]      wide_mux_out,
  output logic                 fast_carry_output
);
  typedef struct packed {
    logic            waitrequest;
    logic [31:0]     rdata;
    logic [31:0]     cfg;
    logic [15:0]     ops;
    logic [3:0]      clk_prev;
    logic [3:0][1:0] q;
    logic [3:0][1:0] f_out;
    logic [3:0]      five;
    logic [3:0]      wide;
    logic            carry;
  } tile_s;

  tile_s st_q;
  tile_s nx;

  table_if tbl ();

  table_store u_store (
    .ref_clk (ref_clk),
    .srst    (srst),
    .tbl     (tbl)
  );

  // truth table lookup
  function automatic logic table_read(logic [15:0] t, logic [3:0] i);
    return t[i];
  endfunction

  // byte-lane write merge
  function automatic logic [31:0] byte_merge(logic [31:0] old, logic [31:0] nw,
                                             logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // two-bit arithmetic unit: {carry out, sum}
  function automatic logic [2:0] ripple2(op_e op, logic [1:0] a, logic [1:0] b,
                                         logic m, logic cin);
    logic [1:0] aa;
    logic [1:0] bb;
    logic [1:0] g;
    logic [1:0] p;
    logic       gen;
    logic       prop;
    logic       c1;
    aa = a;
    bb = b;
    case (op)
      OP_SUB:    bb = ~b;
      OP_ADDSUB: bb = m ? ~b : b;
      OP_UP:     bb = 2'h0;
      OP_DOWN:   bb = 2'h3;
      OP_MULT:   bb = b & {2{m}};
      OP_GE:     bb = ~b;
      OP_LE: begin
        aa = b;
        bb = ~a;
      end
      default:   bb = b;
    endcase
    g    = aa & bb;
    p    = aa ^ bb;
    gen  = g[1] | (p[1] & g[0]);
    prop = p[1] & p[0];
    c1   = g[0] | (p[0] & cin);
    if (op == OP_NE) begin
      return {cin | (a != b), a ^ b};
    end
    return {gen | (prop & cin), p ^ {c1, cin}};
  endfunction

  mode_e           mode_v [NUM_SLICES];
  logic [3:0][1:0] lut_f;
  logic [3:0][1:0] f_val;
  logic [4:0]      chain;
  logic [3:0]      five_c;
  logic [3:0]      evt_c;
  logic [3:0]      lvl_c;
  logic            six0;
  logic            six2;
  logic            seven;
  logic            eight;
  logic            any_ripple;

  always_comb begin
    int         src;
    op_e        op;
    logic [1:0] aa;
    logic [2:0] ar;
    logic       neg;
    logic       act;
    src        = 0;
    op         = OP_ADD;
    aa         = 2'h0;
    ar         = 3'h0;
    neg        = 1'b0;
    act        = 1'b0;
    nx         = st_q;
    lut_f      = '0;
    f_val      = '0;
    five_c     = '0;
    evt_c      = '0;
    lvl_c      = '0;
    chain      = '0;
    any_ripple = 1'b0;
    tbl.bus_we   = 1'b0;
    tbl.bus_idx  = address[3:2];
    tbl.bus_data = byte_merge(tbl.contents[address[3:2]], writedata, byteenable);
    tbl.ram_we   = '0;
    tbl.ram_addr = '0;
    tbl.ram_data = '0;
    chain[0]     = fast_carry_input;
    for (int s = 0; s < NUM_SLICES; s++) begin
      mode_v[s] = mode_e'(st_q.cfg[s*CFG_W+CFG_MODE +: 2]);
      op        = op_e'(st_q.ops[s*OP_W +: OP_W]);
      neg       = st_q.cfg[s*CFG_W+CFG_CLK_NEG];
      src       = ((s % 2 == 1) && st_q.cfg[s*CFG_W+CFG_COMPANION]) ? s - 1 : s;
      lut_f[s][0] = table_read(tbl.contents[s][15:0], table_in[s][3:0]);
      lut_f[s][1] = table_read(tbl.contents[s][31:16], table_in[s][7:4]);
      five_c[s] = multipurpose_in[s][0] ? lut_f[s][1] : lut_f[s][0];
      aa = (op == OP_UP || op == OP_DOWN) ? st_q.q[s] :
           {table_in[s][IN_A1], table_in[s][IN_A0]};
      ar = ripple2(op, aa, {table_in[s][IN_B1], table_in[s][IN_B0]},
                   multipurpose_in[s][0], chain[s]);
      chain[s+1] = chain[s];
      case (mode_v[s])
        MODE_RIPPLE: begin
          f_val[s]   = ar[1:0];
          chain[s+1] = ar[2];
          any_ripple = 1'b1;
        end
        MODE_RAM: begin
          f_val[s] = {table_read(tbl.contents[src][31:16], table_in[s][3:0]),
                      table_read(tbl.contents[src][15:0], table_in[s][3:0])};
        end
        default: begin
          f_val[s] = lut_f[s];
        end
      endcase
      // clock polarity, edge and level detection
      lvl_c[s] = slice_clk[s] ^ neg;
      evt_c[s] = neg ? (st_q.clk_prev[s] & ~slice_clk[s])
                     : (~st_q.clk_prev[s] & slice_clk[s]);
      nx.clk_prev[s] = slice_clk[s];
      if (mode_v[s] == MODE_RAM && TILE_HAS_RAM && src == s &&
          evt_c[s] && table_in[s][IN_RAM_WE]) begin
        tbl.ram_we[s]   = 1'b1;
        tbl.ram_addr[s] = table_in[s][3:0];
        tbl.ram_data[s] = {table_in[s][IN_WDATA1], table_in[s][IN_WDATA0]};
      end
      for (int i = 0; i < 2; i++) begin
        act = st_q.cfg[s*CFG_W+CFG_LATCH0+i] ? lvl_c[s] : evt_c[s];
        if (local_set_clear[s] && (st_q.cfg[s*CFG_W+CFG_CLR_ASYNC] || act)) begin
          nx.q[s][i] = st_q.cfg[s*CFG_W+CFG_CLR_SET];
        end else if (act && clk_enable[s]) begin
          nx.q[s][i] = f_val[s][i];
        end
      end
    end
    // wide multiplexer tree
    six0  = multipurpose_in[0][1] ? five_c[1] : five_c[0];
    six2  = multipurpose_in[2][1] ? five_c[3] : five_c[2];
    seven = multipurpose_in[1][1] ? six2 : six0;
    eight = multipurpose_in[3][1] ? wide_chain_in : seven;
    nx.f_out = f_val;
    nx.five  = five_c;
    nx.wide  = {eight, six2, seven, six0};
    nx.carry = chain[NUM_SLICES];
    // register bus slave
    if ((read || write) && st_q.waitrequest) begin
      nx.waitrequest = 1'b0;
      nx.rdata       = 32'h0000_0000;
      if (read) begin
        if (address <= OFS_TABLE3 && address[1:0] == 2'h0) begin
          nx.rdata = tbl.contents[address[3:2]];
        end else if (address == OFS_SLICE_CFG) begin
          nx.rdata = st_q.cfg;
        end else if (address == OFS_RIPPLE_OP) begin
          nx.rdata = {16'h0000, st_q.ops};
        end else if (address == OFS_STATUS) begin
          nx.rdata[7:0]          = st_q.q;
          nx.rdata[STAT_CARRY]   = st_q.carry;
          nx.rdata[STAT_HAS_RAM] = TILE_HAS_RAM;
        end
      end
    end else if (!st_q.waitrequest) begin
      nx.waitrequest = 1'b1;
      if (write) begin
        if (address <= OFS_TABLE3 && address[1:0] == 2'h0) begin
          tbl.bus_we = 1'b1;
        end else if (address == OFS_SLICE_CFG) begin
          nx.cfg = byte_merge(st_q.cfg, writedata, byteenable);
        end else if (address == OFS_RIPPLE_OP) begin
          nx.ops = 16'(byte_merge({16'h0000, st_q.ops}, writedata, byteenable));
        end
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      st_q             <= '0;
      st_q.waitrequest <= 1'b1;
      st_q.cfg         <= RST_CFG;
      st_q.ops         <= RST_OPS;
    end else begin
      st_q <= nx;
    end
  end

  assign readdata           = st_q.rdata;
  assign waitrequest        = st_q.waitrequest;
  assign table_bypass_out   = st_q.f_out;
  assign storage_out        = st_q.q;
  assign five_input_mux_out = st_q.five;
  assign wide_mux_out       = st_q.wide;
  assign fast_carry_output  = st_q.carry;

  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);

  a_lut_eval: assert property (
    mode_v[0] == MODE_LOGIC |=> table_bypass_out[0][0] == $past(lut_f[0][0]))
    else $error("table output does not follow truth table");

  a_five_mux: assert property (
    multipurpose_in[2][0] |=> five_input_mux_out[2] == $past(lut_f[2][1]))
    else $error("five-input mux did not pick upper table");

  a_latch_follow: assert property (
    st_q.cfg[CFG_LATCH0] && lvl_c[0] && clk_enable[0] && !local_set_clear[0]
    |=> storage_out[0][0] == $past(f_val[0][0]))
    else $error("open latch did not follow its data");

  a_async_force: assert property (
    local_set_clear[1] && st_q.cfg[CFG_W+CFG_CLR_ASYNC]
    |=> storage_out[1] == {2{$past(st_q.cfg[CFG_W+CFG_CLR_SET])}})
    else $error("asynchronous set/clear not applied");

  a_sync_wait: assert property (
    local_set_clear[0] && !st_q.cfg[CFG_CLR_ASYNC] && !evt_c[0] && !lvl_c[0]
    && !clk_enable[0] |=> $stable(storage_out[0]))
    else $error("synchronous set/clear acted without clock");

  a_ce_hold: assert property (
    !clk_enable[3] && !local_set_clear[3] |=> $stable(storage_out[3]))
    else $error("storage changed with clock enable low");

  a_carry_pass: assert property (
    !any_ripple |=> fast_carry_output == $past(fast_carry_input))
    else $error("carry not passed through idle chain");

  a_rom_locked: assert property (
    mode_v[0] == MODE_ROM && !tbl.bus_we |=> $stable(tbl.contents[0]))
    else $error("rom contents changed without programming");

  a_wide_chain: assert property (
    multipurpose_in[3][1] |=> wide_mux_out[3] == $past(wide_chain_in))
    else $error("eight-input mux ignored neighbour tile");

  a_bus_answer: assert property (
    (read || write) && waitrequest |=> !waitrequest ##1 waitrequest)
    else $error("bus answer not given in one cycle");
endmodule
`default_nettype wire

// ### common/slice_pkg.sv
`default_nettype none
package slice_pkg;
  localparam int NUM_SLICES = 4;
  // register byte offsets
  localparam logic [7:0] OFS_TABLE0    = 8'h00;
  localparam logic [7:0] OFS_TABLE3    = 8'h0c;
  localparam logic [7:0] OFS_SLICE_CFG = 8'h10;
  localparam logic [7:0] OFS_RIPPLE_OP = 8'h14;
  localparam logic [7:0] OFS_STATUS    = 8'h18;
  // per-slice configuration byte
  localparam int CFG_W         = 8;
  localparam int CFG_MODE      = 0;
  localparam int CFG_LATCH0    = 2;
  localparam int CFG_CLK_NEG   = 4;
  localparam int CFG_CLR_ASYNC = 5;
  localparam int CFG_CLR_SET   = 6;
  localparam int CFG_COMPANION = 7;
  localparam int OP_W          = 4;
  // status fields
  localparam int STAT_CARRY   = 8;
  localparam int STAT_HAS_RAM = 9;
  // table input positions within a slice
  localparam int IN_A0     = 0;
  localparam int IN_B0     = 1;
  localparam int IN_A1     = 4;
  localparam int IN_B1     = 5;
  localparam int IN_WDATA0 = 5;
  localparam int IN_WDATA1 = 6;
  localparam int IN_RAM_WE = 7;
  // reset values
  localparam logic [31:0] RST_TABLE = 32'h0000_0000;
  localparam logic [31:0] RST_CFG   = 32'h0000_0000;
  localparam logic [15:0] RST_OPS   = 16'h0000;

  typedef enum logic [1:0] {MODE_LOGIC, MODE_RIPPLE, MODE_RAM, MODE_ROM} mode_e;
  typedef enum logic [3:0] {
    OP_ADD, OP_SUB, OP_ADDSUB, OP_UP, OP_DOWN, OP_MULT, OP_GE, OP_NE, OP_LE
  } op_e;
endpackage
`default_nettype wire

// ### common/table_if.sv
`timescale 1ns/100ps
`default_nettype none
interface table_if;
  logic                  bus_we;
  logic [1:0]            bus_idx;
  logic [31:0]           bus_data;
  logic [3:0]            ram_we;
  logic [3:0][3:0]       ram_addr;
  logic [3:0][1:0]       ram_data;
  logic [3:0][31:0]      contents;
  modport owner (input bus_we, bus_idx, bus_data, ram_we, ram_addr, ram_data,
                 output contents);
  modport user  (output bus_we, bus_idx, bus_data, ram_we, ram_addr, ram_data,
                 input contents);
endinterface
`default_nettype wire

// ### logic/table_store.sv
`timescale 1ns/100ps
`default_nettype none
module table_store
  import slice_pkg::*;
(
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic srst,
  // table access
  table_if.owner    tbl
);
  typedef struct packed {
    logic [3:0][31:0] bits;
  } store_s;

  store_s st_q;
  store_s st_d;

  always_comb begin
    st_d = st_q;
    if (tbl.bus_we) begin
      st_d.bits[tbl.bus_idx] = tbl.bus_data;
    end
    for (int s = 0; s < NUM_SLICES; s++) begin
      if (tbl.ram_we[s]) begin
        st_d.bits[s][{1'b0, tbl.ram_addr[s]}] = tbl.ram_data[s][0];
        st_d.bits[s][{1'b1, tbl.ram_addr[s]}] = tbl.ram_data[s][1];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      st_q.bits <= {NUM_SLICES{RST_TABLE}};
    end else begin
      st_q <= st_d;
    end
  end

  assign tbl.contents = st_q.bits;

  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);

  a_ram_write_lo: assert property (
    tbl.ram_we[0] |=> st_q.bits[0][{1'b0, $past(tbl.ram_addr[0])}]
                      == $past(tbl.ram_data[0][0]))
    else $error("ram write did not store low bit");
  a_ram_write_hi: assert property (
    tbl.ram_we[1] |=> st_q.bits[1][{1'b1, $past(tbl.ram_addr[1])}]
                      == $past(tbl.ram_data[1][1]))
    else $error("ram write did not store high bit");
endmodule
`default_nettype wire

// ### bench/route_model.sv
`timescale 1ns/100ps
`default_nettype none
module route_model (
  // clock
  input  wire logic       ref_clk,
  // one slice clock pulse per request
  input  wire logic       tick,
  // slice clocks, still between pulses
  output logic      [3:0] slice_clk
);
  logic [2:0] cnt_q = 3'h0;
  always_ff @(posedge ref_clk) begin
    if (tick) begin
      cnt_q <= 3'h4;
    end else if (cnt_q != 3'h0) begin
      cnt_q <= cnt_q - 3'h1;
    end
  end
  assign slice_clk = {4{cnt_q[2] | cnt_q[1]}};
endmodule
`default_nettype wire

// ### bench/logic_slice_cell_test.sv
`timescale 1ns/100ps
`default_nettype none
module logic_slice_cell_test
  import slice_pkg::*;
;
  logic            ref_clk;
  logic            srst;
  logic [7:0]      address;
  logic            read;
  logic            write;
  logic [31:0]     writedata;
  logic [31:0]     readdata;
  logic            waitrequest;
  logic [3:0][7:0] table_in;
  logic [3:0][1:0] mux_sel;
  logic [3:0]      clk_en;
  logic [3:0]      set_clear;
  logic [3:0]      slice_clk;
  logic            carry_in;
  logic            tick;
  logic [3:0][1:0] bypass;
  logic [3:0][1:0] stored;
  logic [3:0]      five;
  logic [3:0]      wide;
  logic            chain_in;
  logic            carry_out;
  logic [31:0]     q;
  int              n_fail;
  int              tests_run;

  logic_slice_cell #(.TILE_HAS_RAM(1'b1)) i_logic_slice_cell (
    .ref_clk(ref_clk), .srst(srst), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(4'hf),
    .readdata(readdata), .waitrequest(waitrequest), .table_in(table_in),
    .multipurpose_in(mux_sel), .clk_enable(clk_en),
    .local_set_clear(set_clear), .slice_clk(slice_clk),
    .fast_carry_input(carry_in), .wide_chain_in(chain_in),
    .table_bypass_out(bypass), .storage_out(stored),
    .five_input_mux_out(five), .wide_mux_out(wide),
    .fast_carry_output(carry_out));

  route_model i_route_model (.ref_clk(ref_clk), .tick(tick), .slice_clk(slice_clk));

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic acc(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    address <= a;
    writedata <= d;
    write <= we;
    read <= !we;
    do begin
      @(posedge ref_clk);
    end while (waitrequest !== 1'b0);
    q = readdata;
    write <= 1'b0;
    read <= 1'b0;
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge ref_clk);
  endtask

  task automatic pulse;
    tick <= 1'b1;
    @(posedge ref_clk);
    tick <= 1'b0;
    cyc(8);
  endtask

  task automatic stop_test;
    $display("checks %0d failures %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  initial begin
    #100000;
    n_fail++;
    stop_test;
  end

  initial begin
    n_fail = 0;
    tests_run = 0;
    srst = 1'b1;
    address = 8'h00;
    read = 1'b0;
    write = 1'b0;
    writedata = 32'h0;
    table_in = '0;
    mux_sel = '0;
    clk_en = 4'hf;
    set_clear = 4'h0;
    carry_in = 1'b0;
    chain_in = 1'b0;
    tick = 1'b0;
    cyc(10);
    srst <= 1'b0;
    cyc(2);
    // reset values, refused accesses
    acc(1'b0, OFS_SLICE_CFG, 32'h0);
    chk("cfg", q, RST_CFG);
    acc(1'b1, OFS_STATUS, 32'hffff_ffff);
    acc(1'b1, 8'h40, 32'h1);
    acc(1'b0, OFS_STATUS, 32'h0);
    chk("status", q, 32'h200);
    acc(1'b0, 8'h40, 32'h0);
    chk("unmapped", q, 32'h0);
    // logic mode: and / or tables
    acc(1'b1, OFS_TABLE0, 32'hfffe_8000);
    acc(1'b0, OFS_TABLE0, 32'h0);
    chk("table", q, 32'hfffe_8000);
    for (int i = 0; i < 16; i++) begin
      table_in[0] <= {i[3:0], i[3:0]};
      mux_sel[0][0] <= i[0];
      cyc(3);
      chk("f", bypass[0], {30'h0, i != 0, i == 15});
      chk("five", five[0], i[0] ? (i != 0) : (i == 15));
    end
    // storage: capture, hold, sync and async set/clear
    table_in[0] <= 8'hff;
    pulse;
    chk("capture", stored[0], 2'b11);
    clk_en[0] <= 1'b0;
    table_in[0] <= 8'h00;
    pulse;
    chk("hold", stored[0], 2'b11);
    set_clear[0] <= 1'b1;
    cyc(4);
    chk("sync idle", stored[0], 2'b11);
    pulse;
    chk("sync clear", stored[0], 2'b00);
    set_clear[0] <= 1'b0;
    acc(1'b1, OFS_SLICE_CFG, 32'h60);
    set_clear[0] <= 1'b1;
    cyc(4);
    chk("async set", stored[0], 2'b11);
    acc(1'b0, OFS_STATUS, 32'h0);
    chk("status q", q[1:0], 2'b11);
    set_clear[0] <= 1'b0;
    // negative clock: nothing on the rise, capture on the fall
    clk_en[0] <= 1'b1;
    acc(1'b1, OFS_SLICE_CFG, 32'h10);
    tick <= 1'b1;
    @(posedge ref_clk);
    tick <= 1'b0;
    cyc(3);
    chk("neg rise", stored[0], 2'b11);
    cyc(5);
    chk("neg fall", stored[0], 2'b00);
    // ripple: add with carry through the chain, then compare
    acc(1'b1, OFS_RIPPLE_OP, {28'h0, OP_ADD});
    acc(1'b1, OFS_SLICE_CFG, {30'h0, MODE_RIPPLE});
    table_in[0] <= 8'h13;
    cyc(3);
    chk("sum", bypass[0], 2'b00);
    chk("carry", carry_out, 1'b1);
    carry_in <= 1'b1;
    table_in[0] <= 8'h02;
    cyc(3);
    chk("sum cin", bypass[0], 2'b10);
    chk("no carry", carry_out, 1'b0);
    acc(1'b1, OFS_RIPPLE_OP, {28'h0, OP_GE});
    cyc(3);
    chk("ge false", carry_out, 1'b0);
    table_in[0] <= 8'h13;
    cyc(3);
    chk("ge true", carry_out, 1'b1);
    // ram write, then rom refuses a write
    acc(1'b1, OFS_SLICE_CFG, {30'h0, MODE_RAM});
    table_in[0] <= 8'ha5;
    pulse;
    table_in[0] <= 8'h05;
    cyc(3);
    chk("ram rd", bypass[0], 2'b01);
    acc(1'b1, OFS_SLICE_CFG, {30'h0, MODE_ROM});
    table_in[0] <= 8'hc5;
    pulse;
    table_in[0] <= 8'h05;
    cyc(3);
    chk("rom rd", bypass[0], 2'b01);
    // wide multiplexer tree and neighbour tile input
    table_in[0] <= 8'hff;
    mux_sel[3][1] <= 1'b1;
    cyc(3);
    chk("wide local", wide, 4'h3);
    chain_in <= 1'b1;
    mux_sel[0][1] <= 1'b1;
    mux_sel[2][0] <= 1'b1;
    cyc(3);
    chk("wide chain", wide, 4'h8);
    // latch on element 0, flip-flop on element 1
    acc(1'b1, OFS_SLICE_CFG, 32'h04);
    table_in[0] <= 8'h00;
    cyc(3);
    chk("latch shut", stored[0], 2'b11);
    tick <= 1'b1;
    @(posedge ref_clk);
    tick <= 1'b0;
    cyc(1);
    table_in[0] <= 8'hff;
    cyc(6);
    chk("latch open", stored[0], 2'b01);
    // subtract and the other compares
    acc(1'b1, OFS_RIPPLE_OP, {28'h0, OP_SUB});
    acc(1'b1, OFS_SLICE_CFG, {30'h0, MODE_RIPPLE});
    carry_in <= 1'b1;
    table_in[0] <= 8'h13;
    cyc(3);
    chk("sub", bypass[0], 2'b10);
    acc(1'b1, OFS_RIPPLE_OP, {28'h0, OP_LE});
    cyc(3);
    chk("le false", carry_out, 1'b0);
    acc(1'b1, OFS_RIPPLE_OP, {28'h0, OP_NE});
    carry_in <= 1'b0;
    cyc(3);
    chk("ne true", carry_out, 1'b1);
    stop_test;
  end
endmodule
`default_nettype wire
